// ---- pkg/aoc_params.svh ----
// Constants of the analog output channel control block.
// Assumes a 25 MHz clock and a 32-bit APB register bus with byte addresses.
`ifndef AOC_PARAMS_SVH
`define AOC_PARAMS_SVH

// ==========================================================
// Geometry and timing
`define AOC_CHANNELS 4
`define AOC_CLK_KHZ 25000
`define AOC_BLINK_HALF_MS 250
`define AOC_BLINK_CYCLES (`AOC_BLINK_HALF_MS * `AOC_CLK_KHZ)
`define AOC_UPDATE_MAX_US 2500
`define AOC_UPDATE_MAX_CYCLES ((`AOC_UPDATE_MAX_US * `AOC_CLK_KHZ) / 1000)

// ==========================================================
// Value ranges
`define AOC_STD_MIN 16'hD8F0
`define AOC_STD_MAX 16'h2710
`define AOC_SCALE_MUL 32'h0000_346E
`define AOC_CODE_MIN 12'h800
`define AOC_CODE_MAX 12'h7FF
`define AOC_CODE_MIN_W 16'hF800
`define AOC_CODE_MAX_W 16'h07FF

// ==========================================================
// Register byte offsets
`define AOC_REG_CTRL 8'h00
`define AOC_REG_CONFIG 8'h04
`define AOC_REG_FORCE_EN 8'h08
`define AOC_REG_MODSTAT 8'h0C
`define AOC_REG_SETPT0 8'h10
`define AOC_REG_FALLBK0 8'h20
`define AOC_REG_FORCEV0 8'h30
`define AOC_REG_CHSTAT0 8'h40
`define AOC_REG_LAST 8'h4C

// ==========================================================
// Field positions
`define AOC_CTRL_RUN_MAIN 0
`define AOC_CTRL_RUN_FAST 1
`define AOC_CTRL_PROG_PRESENT 2
`define AOC_CFG_STRIDE 4
`define AOC_CFG_RANGE_LSB 0
`define AOC_CFG_MAINTAIN 2
`define AOC_CFG_GROUP 3
`define AOC_ST_ERR 0
`define AOC_ST_OVERSHOOT 1
`define AOC_ST_TERMBLK 2
`define AOC_ST_INTERNAL 3
`define AOC_MS_REPORTED 0
`define AOC_MS_COMM 1
`define AOC_MS_TERMBLK 2

// ==========================================================
// Reset values
`define AOC_CTRL_RESET 32'h0000_0000
`define AOC_CONFIG_RESET 32'h0000_0000
`define AOC_VALUE_RESET 16'h0000

`endif

// ---- pkg/aoc_pkg.sv ----
// Types of the analog output channel control block.
// Assumes aoc_params.svh sits beside it on the include path.
`include "aoc_params.svh"

package aoc_pkg;

   // ==========================================================
   // Output range of one channel
   typedef enum logic [1:0] {
      AOC_RANGE_VOLT = 2'h0,
      AOC_RANGE_4_20 = 2'h1,
      AOC_RANGE_0_20 = 2'h2
   } aoc_range_t;

   typedef logic signed [15:0] aoc_std_t;
   typedef logic signed [11:0] aoc_code_t;

   // True when the value lies outside the standard range
   function automatic logic aoc_out_of_range(input aoc_std_t v);
      return (v < $signed(`AOC_STD_MIN)) || (v > $signed(`AOC_STD_MAX));
   endfunction : aoc_out_of_range

endpackage : aoc_pkg

// ---- logic/aoc_scaler.sv ----
// Clamp of one standard value and scaling to a signed 12-bit converter code.
// Purely combinational; the caller registers the result.
module aoc_scaler
   import aoc_pkg::*;
(
   // Standard value in
   input wire aoc_std_t value,
   // Converter side
   output aoc_code_t code,
   output logic over
);

   aoc_std_t clamped;
   logic signed [31:0] prod;
   logic signed [15:0] scaled;

   // ==========================================================
   // Saturation and scaling
   always_comb begin
      over = aoc_out_of_range(value);
      if (value < $signed(`AOC_STD_MIN)) begin
         clamped = $signed(`AOC_STD_MIN); // [RULE6] [RULE7]
      end else if (value > $signed(`AOC_STD_MAX)) begin
         clamped = $signed(`AOC_STD_MAX); // [RULE6] [RULE7]
      end else begin
         clamped = value;
      end
      // Multiply by 2048/10000 in 16-bit fixed point, zero stays mid-scale
      prod = 32'(clamped) * $signed(`AOC_SCALE_MUL); // [RULE20]
      scaled = prod[31:16];
      if (scaled > $signed(`AOC_CODE_MAX_W)) begin
         code = `AOC_CODE_MAX; // [RULE10]
      end else if (scaled < $signed(`AOC_CODE_MIN_W)) begin
         code = `AOC_CODE_MIN; // [RULE10]
      end else begin
         code = scaled[11:0];
      end
   end

endmodule : aoc_scaler

// ---- logic/aoc_top.sv ----
// Four-channel analog output control with an APB register slave.
// Assumes fault and presence pins are asynchronous; converter loads codes each clock.
// Functional notes
// [RULE1] Four isolated channels, voltage or two current ranges
// [RULE2] Processor sends signed set-points within plus/minus 10000
// [RULE3] Stopped task: fallback or maintain per option
// [RULE4] Fallback values writable at run time
// [RULE5] Forcing allowed only while task stopped
// [RULE6] Voltage channel saturates at ten-volt limits
// [RULE7] Current channels saturate at range limits
// [RULE8] Overshoot sets error and status bit 1
// [RULE9] I/O lamp steady during any overshoot
// [RULE10] Eleven bits plus sign converter code
// [RULE11] Set-point reaches output within 2.5 ms
// [RULE12] Each channel picks one of two task groups
// [RULE13] Self-test failure gives internal fault, lamp steady
// [RULE14] Report internal fault only when communication works
// [RULE15] Five listed test failures never reported
// [RULE16] Terminal block presence checked continuously
// [RULE17] Configuration in, module status out over bus
// [RULE18] Communication fault: fallback/maintain all, error lamp flashes; forced channels keep their forced value
// [RULE19] Terminal block fault: error, status bit 2, lamp flashes
// [RULE20] Linear scaling, zero at mid-scale
module aoc_top
   import aoc_pkg::*;
#(
   parameter int unsigned BLINK_CYCLES = `AOC_BLINK_CYCLES
)(
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Fault and presence pins
   input wire logic commFaultPin,
   input wire logic termBlockPresentPin,
   input wire logic [4:0] selfTestFailPin,
   input wire logic converterFailPin,
   // Converter and output stage
   output aoc_code_t [3:0] dacCode,
   output logic [3:0][1:0] rangeSel,
   output logic [3:0] outEnable,
   // Lamps
   output logic lampRun,
   output logic lampErr,
   output logic lampIo
);

   localparam int NCH = `AOC_CHANNELS;

   // ==========================================================
   // Pin synchronisers
   logic [7:0] syncA;
   logic [7:0] syncB;
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         // Presence bit resets to its idle level, so no false fault follows reset
         syncA <= 8'h02;
         syncB <= 8'h02;
      end else begin
         syncA <= {converterFailPin, selfTestFailPin, termBlockPresentPin, commFaultPin};
         syncB <= syncA;
      end
   end
   logic commFault;
   logic termBlockFault;
   assign commFault = syncB[0];
   assign termBlockFault = !syncB[1]; // [RULE16]

   // ==========================================================
   // Self-test latches, held until reset
   logic hiddenFail;
   logic convFail;
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         hiddenFail <= 1'b0;
         convFail <= 1'b0;
      end else begin
         if (|syncB[6:2]) hiddenFail <= 1'b1; // [RULE13] [RULE15]
         if (syncB[7]) convFail <= 1'b1; // [RULE13]
      end
   end
   logic internalFault;
   logic faultReported;
   assign internalFault = hiddenFail || convFail;
   // Only the converter failure leaves the bus usable
   assign faultReported = convFail && !hiddenFail && !commFault; // [RULE14] [RULE15]

   // ==========================================================
   // Registers
   logic [31:0] ctrlReg;
   logic [31:0] cfgReg;
   logic [31:0] next_ctrlReg;
   logic [31:0] next_cfgReg;
   logic [3:0] forceEn;
   aoc_std_t setPt [NCH];
   aoc_std_t fallBk [NCH];
   aoc_std_t forceVal [NCH];
   logic [3:0] taskRun;
   logic [3:0] over;

   logic setupPh;
   logic wrAcc;
   logic [1:0] chIdx;
   assign setupPh = psel && !penable;
   // Unaligned writes are ignored like out-of-range ones
   assign wrAcc = psel && penable && pwrite && paddr[1:0] == 2'h0;
   assign chIdx = paddr[3:2];

   // Group bit picks the main or fast task run flag
   function automatic logic [3:0] runOf(input logic [31:0] ctl, input logic [31:0] cfg);
      logic [3:0] r;
      for (int c = 0; c < 4; c++) begin
         r[c] = ctl[`AOC_CTRL_PROG_PRESENT]
            && (cfg[c*`AOC_CFG_STRIDE + `AOC_CFG_GROUP]
               ? ctl[`AOC_CTRL_RUN_FAST] : ctl[`AOC_CTRL_RUN_MAIN]);
      end
      return r;
   endfunction : runOf

   always_comb begin
      next_ctrlReg = ctrlReg;
      next_cfgReg = cfgReg;
      if (wrAcc && paddr == `AOC_REG_CTRL) begin
         next_ctrlReg = {29'h0, pwdata[2:0]};
      end
      if (wrAcc && paddr == `AOC_REG_CONFIG) begin
         next_cfgReg = {16'h0, pwdata[15:0]}; // [RULE17]
      end
   end
   assign taskRun = runOf(ctrlReg, cfgReg); // [RULE12]

   always_comb begin
      for (int c = 0; c < NCH; c++) begin
         rangeSel[c] = cfgReg[c*`AOC_CFG_STRIDE + `AOC_CFG_RANGE_LSB +: 2]; // [RULE1]
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         ctrlReg <= `AOC_CTRL_RESET;
         cfgReg <= `AOC_CONFIG_RESET;
      end else begin
         ctrlReg <= next_ctrlReg;
         cfgReg <= next_cfgReg;
      end
   end

   // Masked by the run state after this edge, so a start drops the force at once
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         forceEn <= 4'h0;
      end else if (wrAcc && paddr == `AOC_REG_FORCE_EN) begin
         forceEn <= pwdata[3:0] & ~runOf(next_ctrlReg, next_cfgReg); // [RULE5]
      end else begin
         forceEn <= forceEn & ~runOf(next_ctrlReg, next_cfgReg); // [RULE5]
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         for (int c = 0; c < NCH; c++) begin
            setPt[c] <= `AOC_VALUE_RESET;
            fallBk[c] <= `AOC_VALUE_RESET;
            forceVal[c] <= `AOC_VALUE_RESET;
         end
      end else if (wrAcc) begin
         unique case (paddr[7:4])
            4'h1: setPt[chIdx] <= pwdata[15:0]; // [RULE2]
            4'h2: fallBk[chIdx] <= pwdata[15:0]; // [RULE4]
            4'h3: forceVal[chIdx] <= pwdata[15:0];
            default: ;
         endcase
      end
   end

   // ==========================================================
   // Output selection and scaling
   aoc_std_t selVal [NCH];
   aoc_std_t applied [NCH];
   aoc_code_t code [NCH];

   always_comb begin
      for (int c = 0; c < NCH; c++) begin
         if (forceEn[c]) begin
            selVal[c] = forceVal[c]; // [RULE5]
         end else if (!taskRun[c] || commFault) begin
            // [RULE3] [RULE18] maintain keeps the last value sent
            selVal[c] = cfgReg[c*`AOC_CFG_STRIDE + `AOC_CFG_MAINTAIN] ? setPt[c] : fallBk[c];
         end else begin
            selVal[c] = setPt[c];
         end
      end
   end

   // Terminal block fault freezes every channel
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         for (int c = 0; c < NCH; c++) applied[c] <= `AOC_VALUE_RESET;
      end else if (!termBlockFault) begin
         for (int c = 0; c < NCH; c++) applied[c] <= selVal[c];
      end
   end

   genvar g;
   generate
      for (g = 0; g < NCH; g++) begin : gScale
         aoc_scaler uScale (
            .value(applied[g]),
            .code(code[g]),
            .over(over[g])
         );
      end
   endgenerate

   // Internal fault drives zero with the stage disabled; two cycles from write
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         dacCode <= '0;
         outEnable <= 4'h0;
      end else begin
         for (int c = 0; c < NCH; c++) begin
            dacCode[c] <= internalFault ? 12'h000 : code[c]; // [RULE10] [RULE11]
            outEnable[c] <= !internalFault;
         end
      end
   end

   // ==========================================================
   // Lamps
   logic [23:0] blinkCnt;
   logic blinkPh;
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         blinkCnt <= 24'h00_0000;
         blinkPh <= 1'b0;
      end else if (blinkCnt == 24'(BLINK_CYCLES - 1)) begin
         blinkCnt <= 24'h00_0000;
         blinkPh <= !blinkPh;
      end else begin
         blinkCnt <= blinkCnt + 24'h00_0001;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         lampRun <= 1'b0;
         lampErr <= 1'b0;
         lampIo <= 1'b0;
      end else begin
         lampRun <= !hiddenFail;
         lampErr <= internalFault || (commFault && blinkPh); // [RULE13] [RULE18]
         lampIo <= (|over) || (termBlockFault && blinkPh); // [RULE9] [RULE19]
      end
   end

   // ==========================================================
   // Read path, sampled in the setup phase
   function automatic logic [31:0] chStatus(input logic ov);
      logic [31:0] s;
      s = 32'h0;
      s[`AOC_ST_ERR] = ov || termBlockFault; // [RULE8] [RULE19]
      s[`AOC_ST_OVERSHOOT] = ov; // [RULE8]
      s[`AOC_ST_TERMBLK] = termBlockFault; // [RULE19]
      s[`AOC_ST_INTERNAL] = faultReported;
      return s;
   endfunction : chStatus

   logic [31:0] next_prdata;
   logic next_pslverr;
   always_comb begin
      next_prdata = 32'h0;
      next_pslverr = 1'b0;
      if (paddr[1:0] != 2'h0 || paddr > `AOC_REG_LAST) begin
         next_pslverr = 1'b1;
      end else begin
         unique case (paddr[7:4])
            4'h0: begin
               unique case (paddr[3:2])
                  2'h0: next_prdata = ctrlReg;
                  2'h1: next_prdata = cfgReg;
                  2'h2: next_prdata = {28'h0, forceEn};
                  2'h3: next_prdata = {29'h0, termBlockFault, commFault,
                     faultReported}; // [RULE14] [RULE17]
               endcase
            end
            4'h1: next_prdata = {{16{setPt[chIdx][15]}}, setPt[chIdx]};
            4'h2: next_prdata = {{16{fallBk[chIdx][15]}}, fallBk[chIdx]};
            4'h3: next_prdata = {{16{forceVal[chIdx][15]}}, forceVal[chIdx]};
            default: next_prdata = chStatus(over[chIdx]);
         endcase
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         prdata <= 32'h0000_0000;
         pslverr <= 1'b0;
      end else if (setupPh) begin
         prdata <= next_prdata;
         pslverr <= next_pslverr;
      end
   end
   assign pready = psel && penable;

   // ==========================================================
   // Checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   AST_FORCE_REFUSED: assert property (|(forceEn & taskRun) == 1'b0) // [RULE5]
      else $error("force active on a running channel");
   AST_SET_TO_DAC: assert property (wrAcc && paddr == `AOC_REG_SETPT0 && taskRun[0]
      && !forceEn[0] && !commFault && !termBlockFault && !internalFault && $stable(taskRun)
      |=> ##1 applied[0] == $past(pwdata[15:0], 2) ##1 dacCode[0] == $past(code[0])) // [RULE11]
      else $error("set-point not applied in time");
   AST_CODE_SPAN: assert property (applied[3] == $signed(`AOC_STD_MAX)
      |-> code[3] == `AOC_CODE_MAX) // [RULE20]
      else $error("full scale does not map to top code");
   AST_SATURATE: assert property (applied[0] > $signed(`AOC_STD_MAX)
      |-> code[0] == `AOC_CODE_MAX && over[0]) // [RULE6]
      else $error("overshoot not saturated");
   AST_IO_STEADY: assert property (|over |=> lampIo) // [RULE9]
      else $error("io lamp off during overshoot");
   AST_FREEZE: assert property (termBlockFault |=> applied[2] == $past(applied[2])) // [RULE19]
      else $error("outputs moved during terminal block fault");
   AST_INTERNAL_ZERO: assert property (internalFault |=> outEnable == 4'h0
      && lampErr ##1 dacCode[3] == 12'h000) // [RULE13]
      else $error("internal fault did not zero outputs");
   AST_HIDDEN: assert property (hiddenFail |-> !faultReported) // [RULE15]
      else $error("unreportable fault reported");
   AST_FALLBACK: assert property (!taskRun[0] && !forceEn[0]
      && !cfgReg[`AOC_CFG_MAINTAIN] && !termBlockFault |=> applied[0] == $past(fallBk[0])) // [RULE3]
      else $error("stopped channel not at fallback");
   AST_COMM_ALL: assert property (commFault && !forceEn[2] && !termBlockFault
      && cfgReg[2*`AOC_CFG_STRIDE + `AOC_CFG_MAINTAIN] |=> applied[2] == $past(setPt[2])) // [RULE18]
      else $error("comm fault did not hold channel");

endmodule : aoc_top

// ---- tb/aoc_plc_model.sv ----
// Controlling processor model: an APB master issuing one transfer at a time.
// Assumes it shares the slave's clock; the bench calls its xfer task.
module aoc_plc_model (
   // Clock
   input wire logic clk,
   // APB master side
   output logic psel,
   output logic penable,
   output logic pwrite,
   output logic [7:0] paddr,
   output logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr
);
   timeunit 1ns;
   timeprecision 1ps;

   initial begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0000_0000;
   end

   // ==========================================================
   // Transfer: held until pready is seen high at an edge
   task automatic xfer(input logic wr, input logic [7:0] addr, input logic [31:0] wd,
                       output logic [31:0] rd, output logic err);
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= addr;
      pwdata <= wd;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      // Stale data would hide a slave that samples late
      pwdata <= ~wd;
   endtask : xfer
endmodule : aoc_plc_model

// ---- tb/aoc_top_bench.sv ----
// Self-checking bench of aoc_top against an integer model of the rules.
// Assumes aoc_pkg is compiled first; blink half-period shortened to 4 cycles.
`include "aoc_params.svh"
module aoc_top_bench;
   import aoc_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;

   logic clk = 1'b0;
   logic rst = 1'b1;
   logic psel, penable, pwrite, pready, pslverr;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rdat;
   logic commFaultPin = 1'b0;
   logic termBlockPresentPin = 1'b1;
   logic [4:0] selfTestFailPin = 5'h00;
   logic converterFailPin = 1'b0;
   aoc_code_t [3:0] dacCode;
   logic [3:0][1:0] rangeSel;
   logic [3:0] outEnable;
   logic lampRun, lampErr, lampIo, err;
   int n_fail = 0;
   int n_checks = 0;
   int sp[4], fb[4], fv[4], tbl[6], v, n;
   logic [31:0] ctrl, cfg;
   logic [3:0] fe, ov;
   logic comm = 1'b0;

   always #20 clk = ~clk;

   aoc_top #(.BLINK_CYCLES(4)) aoc_top_inst (.clk(clk), .rst(rst), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .commFaultPin(commFaultPin), .termBlockPresentPin(termBlockPresentPin),
      .selfTestFailPin(selfTestFailPin), .converterFailPin(converterFailPin),
      .dacCode(dacCode), .rangeSel(rangeSel), .outEnable(outEnable),
      .lampRun(lampRun), .lampErr(lampErr), .lampIo(lampIo));

   aoc_plc_model aoc_plc_model_inst (.clk(clk), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr));

   // ==========================================================
   // Model and helpers
   function automatic int scale(input int x);
      int c;
      c = (x < -10000) ? -10000 : (x > 10000) ? 10000 : x;
      c = (c * 13422) >>> 16;
      return (c < -2048) ? -2048 : (c > 2047) ? 2047 : c;
   endfunction : scale

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      aoc_plc_model_inst.xfer(1'b1, a, d, rdat, err);
   endtask : wr

   task automatic rd(input logic [7:0] a);
      aoc_plc_model_inst.xfer(1'b0, a, 32'h0000_0000, rdat, err);
   endtask : rd

   task automatic pins(input int cycles);
      repeat (cycles) @(posedge clk);
   endtask : pins

   task automatic do_reset;
      rst <= 1'b1;
      repeat (16) @(posedge clk);
      selfTestFailPin <= 5'h00;
      converterFailPin <= 1'b0;
      rst <= 1'b0;
      pins(2);
   endtask : do_reset

   task automatic blink(input logic io, output int t);
      logic last;
      t = 0;
      last = io ? lampIo : lampErr;
      repeat (24) begin
         @(posedge clk);
         #1;
         if ((io ? lampIo : lampErr) !== last) t++;
         last = io ? lampIo : lampErr;
      end
   endtask : blink

   task automatic check_all;
      logic run;
      pins(6);
      for (int c = 0; c < 4; c++) begin
         run = ctrl[2] & (cfg[4*c+3] ? ctrl[1] : ctrl[0]) & !comm;
         v = (fe[c] && !run) ? fv[c] : (run || cfg[4*c+2]) ? sp[c] : fb[c];
         chk(32'(dacCode[c]), 32'(scale(v)));
      end
   endtask : check_all

   task automatic complete_run;
      $display("checks %0d failures %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : complete_run

   initial begin
      pins(30000);
      n_fail++;
      $display("mismatch at %0t: got %h expected %h", $time, 0, 1);
      complete_run();
   end

   // ==========================================================
   // Scenarios
   initial begin
      void'($urandom(32'hec4c_c172));
      tbl = '{-10001, -10000, 0, 10000, 10001, -32768};
      sp = '{0, 0, 0, 0};
      fe = 4'h0;
      ov = 4'h0;
      do_reset();
      chk(32'(lampRun), 32'h1);
      rd(8'h00);
      chk(rdat, 32'h0000_0000);
      rd(8'h50);
      chk({rdat[30:0], err}, 32'h0000_0001);
      ctrl = 32'h0000_0005;
      cfg = 32'h0000_0210;
      wr(8'h00, ctrl);
      wr(8'h04, cfg);
      pins(1);
      chk(32'(rangeSel), 32'h0000_0024);
      for (int i = 0; i < 24; i++) begin
         v = (i < 6) ? tbl[i] : int'($urandom_range(40000)) - 20000;
         sp[i%4] = v;
         ov[i%4] = (v < -10000) || (v > 10000);
         wr(8'h10 + 8'(4*(i%4)), 32'(v));
         check_all();
         rd(8'h40 + 8'(4*(i%4)));
         chk(rdat & 32'h3, {30'h0, ov[i%4], ov[i%4]});
         chk(32'(lampIo), 32'(|ov));
      end
      for (int c = 0; c < 4; c++) begin
         fb[c] = int'($urandom_range(20000)) - 10000;
         fv[c] = int'($urandom_range(20000)) - 10000;
         wr(8'h20 + 8'(4*c), 32'(fb[c]));
         wr(8'h30 + 8'(4*c), 32'(fv[c]));
      end
      cfg = 32'h0000_0690;
      wr(8'h04, cfg);
      wr(8'h11, 32'h0000_1234);
      chk(32'(err), 32'h1);
      check_all();
      wr(8'h08, 32'h0000_000F);
      rd(8'h08);
      chk(rdat, 32'h0000_0002);
      fe = 4'h2;
      check_all();
      ctrl = 32'h0000_0004;
      wr(8'h00, ctrl);
      wr(8'h08, 32'h0000_000F);
      fe = 4'hF;
      check_all();
      wr(8'h08, 32'h0000_0000);
      fe = 4'h0;
      fb[0] = -1234;
      wr(8'h20, 32'(fb[0]));
      check_all();
      ctrl = 32'h0000_0007;
      wr(8'h00, ctrl);
      commFaultPin <= 1'b1;
      comm = 1'b1;
      check_all();
      rd(8'h0C);
      chk(rdat & 32'h2, 32'h2);
      blink(1'b0, n);
      chk(32'(n > 2), 32'h1);
      commFaultPin <= 1'b0;
      comm = 1'b0;
      // In-range set-points, so the I/O lamp can flash later
      for (int c = 0; c < 4; c++) begin
         sp[c] = int'($urandom_range(20000)) - 10000;
         wr(8'h10 + 8'(4*c), 32'(sp[c]));
      end
      check_all();
      termBlockPresentPin <= 1'b0;
      pins(6);
      wr(8'h10, 32'h0000_1000);
      check_all();
      rd(8'h40);
      chk(rdat & 32'h5, 32'h5);
      blink(1'b1, n);
      chk(32'(n > 2), 32'h1);
      termBlockPresentPin <= 1'b1;
      sp[0] = 32'h0000_1000;
      check_all();
      converterFailPin <= 1'b1;
      pins(6);
      rd(8'h0C);
      chk({rdat[0], lampErr, lampRun, outEnable, dacCode[0]}, 32'h0007_0000);
      for (int k = 0; k < 5; k++) begin
         do_reset();
         selfTestFailPin <= 5'(1 << k);
         pins(6);
         rd(8'h0C);
         chk({rdat[0], lampErr, lampRun, outEnable}, 32'h0000_0020);
      end
      complete_run();
   end
endmodule : aoc_top_bench
